// ### src/pwm_fb_pkg.sv
// Shared constants, register map and carrier types for the falling blank and output F steer block.
package pwm_fb_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the Avalon-MM slave)
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_FALLING_BLANK_TIME = 4'h0;
    localparam logic [3:0] OFS_OUTPUT_STEERING    = 4'h4;
    localparam logic [3:0] OFS_MODE_CONTROL       = 4'h8;
    localparam logic [3:0] OFS_STATUS             = 4'hc;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         STEER_F_BIT       = 5;
    localparam int         STEER_WIDTH       = 6;
    localparam int         STAT_BLANK_BIT    = 0;
    localparam int         STAT_OUT_F_BIT    = 1;
    localparam logic [7:0] RST_FALLING_BLANK = 8'h00;
    localparam logic [5:0] RST_STEERING      = 6'h01;
    localparam logic [3:0] RST_MODE          = 4'h0;
    localparam logic [7:0] RST_DIV_CNT       = 8'h00;

    // ------------------------------------------------------------------
    // Output mode codes and drive levels
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_SINGLE     = 4'h0;
    localparam logic [3:0] MODE_COMPL      = 4'h1;
    localparam logic       INACTIVE_LEVEL  = 1'b0;
    localparam int         MOD_DIV_DEFAULT = 1;
    localparam int         MOD_DIV_MAX     = 256;

    // Bus handshake state, Gray along idle -> answer -> idle.
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_e;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } bus_req_s;

    // Avalon-MM answer to the master.
    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } bus_rsp_s;

    // State of the blanking timer.
    typedef struct packed {
        logic [7:0] cnt;
        logic       active;
    } blank_state_s;

    // State of the top block.
    typedef struct packed {
        bus_state_e  bus;
        logic [31:0] rdata;
        logic [7:0]  blank_time;
        logic [5:0]  steer;
        logic [3:0]  mode;
        logic [7:0]  div_cnt;
        logic        tick;
        logic        pwm_prev;
        logic        out_f;
    } top_state_s;

endpackage

// ### src/fall_blank_timer.sv
// Falling-edge blanking timer counted in modulator clock periods.
`timescale 1ns/1ps

module fall_blank_timer (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Timing controls.
    input  wire logic       tick_i,
    input  wire logic       fall_i,
    input  wire logic [7:0] count_i,
    // Blanking window.
    output logic            active_o
);

    pwm_fb_pkg::blank_state_s st_q;
    pwm_fb_pkg::blank_state_s st_d;

    // A falling edge reloads the window, even one that lands inside a running window,
    // so the blanking always covers the latest edge. A zero count gives no window.
    always_comb begin
        st_d = st_q;
        if (fall_i) begin
            st_d.cnt = count_i;
        end else if (tick_i && (st_q.cnt != 8'h00)) begin
            st_d.cnt = st_q.cnt - 8'h01;
        end
        st_d.active = (st_d.cnt != 8'h00);
    end

    // State register.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign active_o = st_q.active;

endmodule

// ### src/pwm_fall_blank_steer_f.sv
// Falling-edge blanking time and output F steering, with an Avalon-MM register slave.
//
// Notes on behaviour
// - Falling blank field is an unsigned count of modulator clock periods of blanking.
// - Steering bits seven and six read zero; writes to them do nothing.
// - Any reset clears blank count and steer bits five to one, sets steer bit zero.
// - Complementary mode with F steer set puts the complementary waveform on output F.
// - Complementary mode with F steer clear holds output F at the inactive level.
// - F steer enable is steering bit five; its meaning depends on output mode.
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

module pwm_fall_blank_steer_f #(
    parameter int MOD_DIV = pwm_fb_pkg::MOD_DIV_DEFAULT
) (
    // Clock and reset.
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    // Avalon-MM register slave.
    input  wire pwm_fb_pkg::bus_req_s avs_req_i,
    output pwm_fb_pkg::bus_rsp_s      avs_rsp_o,
    // Modulator waveform in, active high.
    input  wire logic                 pwm_i,
    // Power-stage and neighbour outputs.
    output logic                      output_f_o,
    output logic                      blank_active_o,
    output logic [5:0]                steer_enables_o,
    output logic [3:0]                output_mode_select_o
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if ((MOD_DIV < 1) || (MOD_DIV > pwm_fb_pkg::MOD_DIV_MAX)) begin : g_chk_div
        $error("MOD_DIV must lie between 1 and 256");
    end

    localparam logic [7:0] DIV_LAST = 8'((MOD_DIV - 1) & 8'hff);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Register index from a byte address; 3'h4 marks an unmapped address.
    function automatic logic [2:0] reg_index(input logic [3:0] addr);
        if (addr == pwm_fb_pkg::OFS_FALLING_BLANK_TIME) begin
            reg_index = 3'h0;
        end else if (addr == pwm_fb_pkg::OFS_OUTPUT_STEERING) begin
            reg_index = 3'h1;
        end else if (addr == pwm_fb_pkg::OFS_MODE_CONTROL) begin
            reg_index = 3'h2;
        end else if (addr == pwm_fb_pkg::OFS_STATUS) begin
            reg_index = 3'h3;
        end else begin
            reg_index = 3'h4;
        end
    endfunction

    // Output F level for a mode, steer bit and waveform.
    function automatic logic f_level(input logic [3:0] mode, input logic steer_f,
                                     input logic pwm);
        if (!steer_f) begin
            f_level = pwm_fb_pkg::INACTIVE_LEVEL;
        end else if (mode == pwm_fb_pkg::MODE_SINGLE) begin
            f_level = pwm;
        end else if (mode == pwm_fb_pkg::MODE_COMPL) begin
            f_level = ~pwm;
        end else begin
            f_level = pwm_fb_pkg::INACTIVE_LEVEL;
        end
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pwm_fb_pkg::top_state_s st_q;
    pwm_fb_pkg::top_state_s st_d;
    logic                   blank_active;
    logic                   req;
    logic                   take;
    logic                   fall;
    logic [2:0]             idx;

    assign req  = avs_req_i.read | avs_req_i.write;
    assign take = req && (st_q.bus == pwm_fb_pkg::BUS_ACK);
    assign fall = st_q.pwm_prev & ~pwm_i;
    assign idx  = reg_index(avs_req_i.address);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // The bus answers one cycle after the request appears: read data is captured in the
    // first cycle and stands while waitrequest is low, and a write lands one edge later, on the edge that samples waitrequest low.
    // The extra cycle costs bandwidth but keeps readdata straight from a flip-flop.
    always_comb begin
        st_d = st_q;
        // Modulator clock enable from the divider.
        if (st_q.div_cnt == DIV_LAST) begin
            st_d.div_cnt = pwm_fb_pkg::RST_DIV_CNT;
            st_d.tick    = 1'b1;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 8'h01;
            st_d.tick    = 1'b0;
        end
        st_d.pwm_prev = pwm_i;
        // Output F steering, registered so the pin sees no decode glitches.
        st_d.out_f = f_level(st_q.mode, st_q.steer[pwm_fb_pkg::STEER_F_BIT], pwm_i);
        // Bus handshake.
        if (take) begin
            st_d.bus = pwm_fb_pkg::BUS_IDLE;
        end else if (req) begin
            st_d.bus   = pwm_fb_pkg::BUS_ACK;
            st_d.rdata = 32'h0000_0000;
            if (idx == 3'h0) begin
                st_d.rdata[7:0] = st_q.blank_time;
            end else if (idx == 3'h1) begin
                st_d.rdata[5:0] = st_q.steer;
            end else if (idx == 3'h2) begin
                st_d.rdata[3:0] = st_q.mode;
            end else if (idx == 3'h3) begin
                st_d.rdata[pwm_fb_pkg::STAT_BLANK_BIT] = blank_active;
                st_d.rdata[pwm_fb_pkg::STAT_OUT_F_BIT] = st_q.out_f;
            end
        end
        // Register writes use byte lane 0 only; the upper lanes hold no bits.
        if (take && avs_req_i.write && avs_req_i.byteenable[0]) begin
            if (idx == 3'h0) begin
                st_d.blank_time = avs_req_i.writedata[7:0];
            end else if (idx == 3'h1) begin
                st_d.steer = avs_req_i.writedata[5:0];
            end else if (idx == 3'h2) begin
                st_d.mode = avs_req_i.writedata[3:0];
            end
        end
    end

    // State register; every reset kind arrives here as the one reset input.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q.bus        <= pwm_fb_pkg::BUS_IDLE;
            st_q.rdata      <= 32'h0000_0000;
            st_q.blank_time <= pwm_fb_pkg::RST_FALLING_BLANK;
            st_q.steer      <= pwm_fb_pkg::RST_STEERING;
            st_q.mode       <= pwm_fb_pkg::RST_MODE;
            st_q.div_cnt    <= pwm_fb_pkg::RST_DIV_CNT;
            st_q.tick       <= 1'b0;
            st_q.pwm_prev   <= 1'b0;
            st_q.out_f      <= pwm_fb_pkg::INACTIVE_LEVEL;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Blanking timer
    // ------------------------------------------------------------------
    fall_blank_timer u_blank (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .tick_i   (st_q.tick),
        .fall_i   (fall),
        .count_i  (st_q.blank_time),
        .active_o (blank_active)
    );

    // Outputs.
    assign avs_rsp_o.waitrequest = req && (st_q.bus == pwm_fb_pkg::BUS_IDLE);
    assign avs_rsp_o.readdata    = st_q.rdata;
    assign output_f_o            = st_q.out_f;
    assign blank_active_o        = blank_active;
    assign steer_enables_o       = st_q.steer;
    assign output_mode_select_o  = st_q.mode;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    // Length of the current blanking window and the count that started it.
    logic [17:0] blank_len_q;
    logic [7:0]  blank_load_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            blank_len_q  <= 18'h0_0000;
            blank_load_q <= 8'h00;
        end else if (fall) begin
            blank_len_q  <= 18'h0_0000;
            blank_load_q <= st_q.blank_time;
        end else if (blank_active) begin
            blank_len_q <= blank_len_q + 18'h0_0001;
        end
    end

    property p_blank_start;
        @(posedge clk_i) disable iff (!nrst_i)
        (fall && (st_q.blank_time != 8'h00)) |=> blank_active;
    endproperty
    a_blank_start: assert property (p_blank_start) else $error("blanking did not start");

    property p_blank_zero;
        @(posedge clk_i) disable iff (!nrst_i)
        (fall && (st_q.blank_time == 8'h00) && !blank_active) |=> !blank_active;
    endproperty
    a_blank_zero: assert property (p_blank_zero) else $error("zero count blanked");

    property p_blank_len;
        @(posedge clk_i) disable iff (!nrst_i)
        blank_active |-> (blank_len_q < (18'(blank_load_q) * 18'(MOD_DIV)));
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("blanking ran too long");

    property p_steer_read_top;
        @(posedge clk_i) disable iff (!nrst_i)
        (take && avs_req_i.read && (idx == 3'h1)) |-> (avs_rsp_o.readdata[31:6] == 26'h0);
    endproperty
    a_steer_read_top: assert property (p_steer_read_top) else $error("steer top bits nonzero");

    property p_reset_values;
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> ((st_q.steer == 6'h01) && (st_q.blank_time == 8'h00));
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values");

    property p_compl_on;
        @(posedge clk_i) disable iff (!nrst_i)
        ((st_q.mode == 4'h1) && st_q.steer[5]) |=> (output_f_o == !$past(pwm_i));
    endproperty
    a_compl_on: assert property (p_compl_on) else $error("output F not complementary");

    property p_compl_off;
        @(posedge clk_i) disable iff (!nrst_i)
        ((st_q.mode == 4'h1) && !st_q.steer[5]) |=> (output_f_o == 1'b0);
    endproperty
    a_compl_off: assert property (p_compl_off) else $error("output F not inactive");

    property p_steer_write;
        @(posedge clk_i) disable iff (!nrst_i)
        (take && avs_req_i.write && (idx == 3'h1) && avs_req_i.byteenable[0])
        |=> (steer_enables_o[5] == $past(avs_req_i.writedata[5]));
    endproperty
    a_steer_write: assert property (p_steer_write) else $error("F steer bit not stored");

    property p_single;
        @(posedge clk_i) disable iff (!nrst_i)
        (st_q.mode == 4'h0) |=> (output_f_o == ($past(st_q.steer[5]) & $past(pwm_i)));
    endproperty
    a_single: assert property (p_single) else $error("single mode output F wrong");

    property p_answer_bound;
        @(posedge clk_i) disable iff (!nrst_i)
        (req && !take) |=> take;
    endproperty
    a_answer_bound: assert property (p_answer_bound) else $error("bus answer late");

    // Main scenarios.
    c_compl_pulse: cover property (@(posedge clk_i) disable iff (!nrst_i)
        (st_q.mode == 4'h1) && st_q.steer[5] && fall);
    c_blank_window: cover property (@(posedge clk_i) disable iff (!nrst_i)
        blank_active ##1 !blank_active);
    c_steer_write: cover property (@(posedge clk_i) disable iff (!nrst_i)
        take && avs_req_i.write && (idx == 3'h1));
    c_unmapped_read: cover property (@(posedge clk_i) disable iff (!nrst_i)
        take && avs_req_i.read && (idx == 3'h4));

endmodule

// ### verification/switch_driver_model.sv
// Power switch driver model that follows the output F pin and counts its switching edges.
`timescale 1ns/1ps

module switch_driver_model (
    // Clock and reset.
    input  wire logic   clk_i,
    input  wire logic   nrst_i,
    // Power-stage pin.
    input  wire logic   gate_i,
    // Observed state.
    output logic        gate_o,
    output logic [15:0] edges_o
);
    logic prev_q;

    // The gate follows the pin at once; the edge count shows a pin that should stay quiet.
    assign gate_o = gate_i;

    // Count each change of the pin level seen at a rising clock edge; a glitch between samples is not counted.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev_q  <= 1'b0;
            edges_o <= 16'h0000;
        end else begin
            prev_q <= gate_i;
            if (gate_i != prev_q) begin
                edges_o <= edges_o + 16'h0001;
            end
        end
    end
endmodule

// ### verification/pwm_fall_blank_steer_f_tb.sv
// Self-checking testbench for the falling blank and output F steer block.
`timescale 1ns/1ps

module pwm_fall_blank_steer_f_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                 clk_i = 1'b0;
    logic                 nrst_i = 1'b0;
    pwm_fb_pkg::bus_req_s req = '0;
    pwm_fb_pkg::bus_rsp_s rsp;
    logic                 pwm_i = 1'b0;
    logic                 output_f_o;
    logic                 blank_active_o;
    logic [5:0]           steer_enables_o;
    logic [3:0]           output_mode_select_o;
    logic                 gate;
    logic [15:0]          edges;
    int                   bad_count = 0;
    int                   cmp_count = 0;
    int                   cycles = 0;
    logic [31:0]          rd;

    // ------------------------------------------------------------------
    // Design, partner and clock
    // ------------------------------------------------------------------
    pwm_fall_blank_steer_f #(.MOD_DIV(1)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .avs_req_i(req), .avs_rsp_o(rsp), .pwm_i(pwm_i),
        .output_f_o(output_f_o), .blank_active_o(blank_active_o),
        .steer_enables_o(steer_enables_o), .output_mode_select_o(output_mode_select_o));
    switch_driver_model drv (.clk_i(clk_i), .nrst_i(nrst_i), .gate_i(output_f_o),
        .gate_o(gate), .edges_o(edges));

    always #2.5 clk_i = ~clk_i;

    // A hung handshake must not stall the run forever.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles >= 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds the request until a rising edge samples waitrequest low, takes read data at
    // that same edge and only then releases it, so the write lands on the answering edge.
    task automatic bus(input logic is_rd, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] data);
        int n;
        n = 0;
        @(posedge clk_i);
        req.read       <= is_rd;
        req.write      <= !is_rd;
        req.address    <= a;
        req.writedata  <= wd;
        req.byteenable <= 4'hf;
        @(posedge clk_i);
        while (rsp.waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 50) begin
            bad_count++;
            complete_run();
        end
        data = rsp.readdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic [31:0] d;
        bus(1'b0, a, {24'h000000, v}, d);
    endtask

    task automatic apply_reset();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
    endtask

    // Drives one pwm level and checks the pin one cycle later through the driver model.
    task automatic pin(input logic v, input logic exp);
        @(posedge clk_i);
        pwm_i <= v;
        @(posedge clk_i);
        @(negedge clk_i);
        cmp_word("output_f", {31'h0, exp}, {31'h0, gate});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic check_defaults();
        bus(1'b1, pwm_fb_pkg::OFS_FALLING_BLANK_TIME, 32'h0, rd);
        cmp_word("falling_blank_time", 32'h00000000, rd);
        bus(1'b1, pwm_fb_pkg::OFS_OUTPUT_STEERING, 32'h0, rd);
        cmp_word("output_steering", 32'h00000001, rd);
        cmp_word("steer_enables", 32'h00000001, {26'h0, steer_enables_o});
    endtask

    task automatic steer_bits();
        wr(pwm_fb_pkg::OFS_OUTPUT_STEERING, 8'hff);
        bus(1'b1, pwm_fb_pkg::OFS_OUTPUT_STEERING, 32'h0, rd);
        cmp_word("steer readback", 32'h0000003f, rd);
        wr(pwm_fb_pkg::OFS_OUTPUT_STEERING, 8'hdf);
        // The write lands on the answering edge; look once the register has settled.
        @(negedge clk_i);
        cmp_word("steer f bit", 32'h0000001f, {26'h0, steer_enables_o});
        bus(1'b1, 4'h2, 32'h0, rd);
        cmp_word("unmapped read", 32'h00000000, rd);
    endtask

    // Single, complementary and one other mode, steer set then cleared; the cleared pin
    // must not switch at all, and a mode outside the two keeps the pin inactive.
    task automatic steer_modes();
        logic [15:0] e0;
        for (int m = 0; m < 3; m++) begin
            wr(pwm_fb_pkg::OFS_MODE_CONTROL, 8'(m));
            wr(pwm_fb_pkg::OFS_OUTPUT_STEERING, 8'h20);
            cmp_word("mode", 32'(m), {28'h0, output_mode_select_o});
            pin(1'b1, (m == 0));
            pin(1'b0, (m == 1));
            pin(1'b1, (m == 0));
            wr(pwm_fb_pkg::OFS_OUTPUT_STEERING, 8'h1f);
            pin(1'b0, pwm_fb_pkg::INACTIVE_LEVEL);
            e0 = edges;
            pin(1'b1, pwm_fb_pkg::INACTIVE_LEVEL);
            pin(1'b0, pwm_fb_pkg::INACTIVE_LEVEL);
            cmp_word("pin edges", {16'h0, e0}, {16'h0, edges});
        end
    endtask

    // Window length equals the count, including zero and the largest count.
    task automatic blank_len(input logic [7:0] n);
        int hi;
        hi = 0;
        wr(pwm_fb_pkg::OFS_FALLING_BLANK_TIME, n);
        @(posedge clk_i);
        pwm_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        pwm_i <= 1'b0;
        repeat (int'(n) + 6) begin
            @(negedge clk_i);
            hi += int'(blank_active_o === 1'b1);
        end
        cmp_word("blank cycles", {24'h0, n}, 32'(hi));
    endtask

    task automatic reset_midrun();
        wr(pwm_fb_pkg::OFS_FALLING_BLANK_TIME, 8'h5a);
        wr(pwm_fb_pkg::OFS_OUTPUT_STEERING, 8'h3e);
        apply_reset();
        check_defaults();
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        apply_reset();
        check_defaults();
        steer_bits();
        steer_modes();
        blank_len(8'h00);
        blank_len(8'h03);
        blank_len(8'hff);
        reset_midrun();
        complete_run();
    end
endmodule
